// ### logic/uarx_params.svh
// Constants for the asynchronous serial receive front end.
`ifndef UARX_PARAMS_SVH
`define UARX_PARAMS_SVH
`define UARX_SPB_NORMAL      5'd16
`define UARX_SPB_DOUBLE      5'd8
`define UARX_VOTE_FIRST_NRM  5'd8
`define UARX_VOTE_FIRST_DBL  5'd4
`define UARX_DATA_BITS       4'd8
`define UARX_FIFO_DEPTH      2
`define UARX_REG_DATA        4'h0
`define UARX_REG_STATUS      4'h1
`define UARX_REG_CTRL        4'h2
`define UARX_REG_IRQ_STAT    4'h3
`define UARX_REG_IRQ_EN      4'h4
`define UARX_REG_IRQ_CLR     4'h5
`define UARX_CTRL_RESET      8'h00
`define UARX_BIT_RECEIVER_ENABLE        0
`define UARX_BIT_DSPEED      1
`define UARX_BIT_PAREN       2
`define UARX_BIT_PARODD      3
`define UARX_IRQ_RXC         0
`define UARX_IRQ_FE          1
`define UARX_IRQ_DOR         2
`define UARX_IRQ_PE          3
`endif

// ### logic/uarx_pkg.sv
// Types for the asynchronous serial receive front end.
package uarx_pkg;
  typedef enum logic [1:0] {
    UARX_HUNT  = 2'b00,
    UARX_ARMED = 2'b01,
    UARX_START = 2'b10,
    UARX_BITS  = 2'b11
  } uarx_state_t;
  typedef logic [10:0] uarx_entry_t;
endpackage

// ### logic/uarx_sync.sv
// Two-stage synchroniser for the serial receive line.
module uarx_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Line
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= 1'b1;
      q_o    <= 1'b1;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // uarx_sync

// ### logic/uarx_fifo.sv
// Two-entry receive buffer with registered read data.
module uarx_fifo (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  flush_i,
  // Write side
  input  wire logic                  wr_i,
  input  wire uarx_pkg::uarx_entry_t wdata_i,
  output logic                       full_o,
  // Read side
  input  wire logic                  rd_i,
  output uarx_pkg::uarx_entry_t      head_o,
  output logic                       empty_o
);
  import uarx_pkg::*;
  uarx_entry_t mem_q [2];
  logic        wp_q;
  logic        rp_q;
  logic [1:0]  cnt_q;
  wire         do_wr = wr_i && (cnt_q != 2'd2);
  wire         do_rd = rd_i && (cnt_q != 2'd0);
  assign full_o  = (cnt_q == 2'd2);
  assign empty_o = (cnt_q == 2'd0);
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem_q[wp_q] <= wdata_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i || flush_i) begin
      wp_q   <= 1'b0;
      rp_q   <= 1'b0;
      cnt_q  <= 2'd0;
    end else begin
      wp_q  <= wp_q ^ do_wr;
      rp_q  <= rp_q ^ do_rd;
      cnt_q <= cnt_q + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
  // Head is registered: next-state view of the oldest entry.
  always_ff @(posedge clk_i) begin
    if (srst_i || flush_i) begin
      head_o <= '0;
    end else if (do_wr && (cnt_q == 2'd0 || (cnt_q == 2'd1 && do_rd))) begin
      head_o <= wdata_i;
    end else if (do_rd && cnt_q == 2'd2) begin
      head_o <= mem_q[~rp_q];
    end
  end
endmodule // uarx_fifo

// ### logic/uarx_core.sv
// Asynchronous receive front end: start qualification, voting and buffering.
`include "uarx_params.svh"
module uarx_core (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // Baud generator tick and serial line
  input  wire logic       baud_tick_i,
  input  wire logic       rxd_i,
  // Register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  // Interrupt
  output logic            irq_o
);
  import uarx_pkg::*;

  // ----------------------------------------------------------------
  // Synchroniser and control
  // ----------------------------------------------------------------
  logic rx_s;
  uarx_sync u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (rxd_i),
    .q_o    (rx_s)
  );

  logic [7:0] ctrl_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_en_q;
  wire receiver_enable     = ctrl_q[`UARX_BIT_RECEIVER_ENABLE];
  wire double_speed_select = ctrl_q[`UARX_BIT_DSPEED];
  wire parity_check_enable = ctrl_q[`UARX_BIT_PAREN];
  wire parity_odd          = ctrl_q[`UARX_BIT_PARODD];

  wire wr_ctrl  = wr_i && (addr_i == `UARX_REG_CTRL);
  wire wr_ien   = wr_i && (addr_i == `UARX_REG_IRQ_EN);
  wire wr_iclr  = wr_i && (addr_i == `UARX_REG_IRQ_CLR);
  wire rd_data  = rd_i && (addr_i == `UARX_REG_DATA);

  // ----------------------------------------------------------------
  // Sampling state
  // ----------------------------------------------------------------
  uarx_state_t state_q;
  logic [4:0]  samp_q;
  logic [3:0]  bit_q;
  logic [2:0]  votes_q;
  logic [8:0]  shift_q;
  logic        shift_full_q;
  uarx_entry_t shift_ent_q;
  logic        dor_pend_q;

  wire [4:0] spb      = double_speed_select ? `UARX_SPB_DOUBLE : `UARX_SPB_NORMAL;
  wire [4:0] v_first  = double_speed_select ? `UARX_VOTE_FIRST_DBL
                                            : `UARX_VOTE_FIRST_NRM;
  wire       tick     = baud_tick_i && receiver_enable;
  wire       in_vote  = (samp_q >= v_first) && (samp_q <= v_first + 5'd2);
  wire       last_v   = (samp_q == v_first + 5'd2);

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  wire [2:0] vote_all = {votes_q[1:0], rx_s};
  wire       voted    = maj3(vote_all);
  wire       is_stop  = (bit_q == `UARX_DATA_BITS + {3'd0, parity_check_enable});
  wire       frame_done = tick && (state_q == UARX_BITS) && last_v && is_stop;
  wire       start_ok   = tick && (state_q == UARX_START) && last_v && !voted;

  logic        fifo_full;
  logic        fifo_empty;
  uarx_entry_t fifo_head;
  wire         push = shift_full_q && !fifo_full;
  wire         new_start = tick && (state_q == UARX_ARMED) && !rx_s;

  wire [7:0]   data_b   = shift_q[7:0];
  wire         par_calc = ^data_b ^ parity_odd;
  wire         pe_bit   = parity_check_enable && (par_calc != shift_q[8]);
  wire         fe_bit   = !voted;

  always_ff @(posedge clk_i) begin
    if (srst_i || !receiver_enable) begin
      state_q <= UARX_HUNT;
      samp_q  <= 5'd0;
      bit_q   <= 4'd0;
      votes_q <= 3'd0;
      shift_q <= 9'd0;
    end else if (tick) begin
      votes_q <= in_vote ? vote_all : votes_q;
      unique case (state_q)
        UARX_HUNT: begin
          if (rx_s) state_q <= UARX_ARMED;
        end
        UARX_ARMED: begin
          if (!rx_s) begin
            state_q <= UARX_START;
            samp_q  <= 5'd2;
          end
        end
        UARX_START: begin
          samp_q <= samp_q + 5'd1;
          if (last_v) begin
            // Realign: sample numbering continues from the start bit.
            state_q <= voted ? UARX_HUNT : UARX_BITS;
            bit_q   <= 4'd0;
          end
        end
        UARX_BITS: begin
          samp_q <= (samp_q == spb) ? 5'd1 : samp_q + 5'd1;
          if (last_v) begin
            if (is_stop) begin
              state_q <= UARX_HUNT;
              samp_q  <= 5'd0;
            end else begin
              shift_q[bit_q] <= voted;
              bit_q          <= bit_q + 4'd1;
            end
          end
        end
      endcase
    end
  end

  // Shifter holds a finished frame while the buffer is full.
  always_ff @(posedge clk_i) begin
    if (srst_i || !receiver_enable) begin
      shift_full_q <= 1'b0;
      shift_ent_q  <= '0;
      dor_pend_q   <= 1'b0;
    end else begin
      if (frame_done) begin
        shift_full_q <= 1'b1;
        shift_ent_q  <= {dor_pend_q, pe_bit, fe_bit, data_b};
      end else if (push) begin
        shift_full_q <= 1'b0;
      end
      if (new_start && fifo_full && shift_full_q) begin
        dor_pend_q       <= 1'b1;
        shift_ent_q[10]  <= 1'b1;
      end else if (push && !frame_done) begin
        dor_pend_q <= 1'b0;
      end
    end
  end

  uarx_fifo u_fifo (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .flush_i (!receiver_enable),
    .wr_i    (push),
    .wdata_i (shift_ent_q),
    .full_o  (fifo_full),
    .rd_i    (rd_data),
    .head_o  (fifo_head),
    .empty_o (fifo_empty)
  );

  // ----------------------------------------------------------------
  // Registers and interrupt
  // ----------------------------------------------------------------
  wire receive_complete_flag = !fifo_empty;
  wire framing_error_flag    = fifo_head[8] && !fifo_empty;
  wire parity_error_flag     = fifo_head[9] && !fifo_empty;
  wire data_overrun_flag     = fifo_head[10] && !fifo_empty;
  wire [3:0] irq_set = {pe_bit && frame_done, new_start && fifo_full && shift_full_q,
                        fe_bit && frame_done, push};
  wire [7:0] status_v = {4'd0, parity_error_flag, data_overrun_flag,
                         framing_error_flag, receive_complete_flag};
  wire [7:0] rd_mux =
    (addr_i == `UARX_REG_DATA)     ? (fifo_empty ? 8'h00 : fifo_head[7:0]) :
    (addr_i == `UARX_REG_STATUS)   ? status_v :
    (addr_i == `UARX_REG_CTRL)     ? ctrl_q :
    (addr_i == `UARX_REG_IRQ_STAT) ? {4'd0, irq_stat_q} :
    (addr_i == `UARX_REG_IRQ_EN)   ? {4'd0, irq_en_q} : 8'h00;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q     <= `UARX_CTRL_RESET;
      irq_en_q   <= 4'd0;
      irq_stat_q <= 4'd0;
      rdata_o    <= 8'h00;
    end else begin
      if (wr_ctrl) ctrl_q <= wdata_i;
      if (wr_ien) irq_en_q <= wdata_i[3:0];
      // Set wins over a clear in the same cycle.
      irq_stat_q <= (irq_stat_q & ~(wr_iclr ? wdata_i[3:0] : 4'd0)) | irq_set;
      rdata_o    <= rd_i ? rd_mux : 8'h00;
    end
  end
  assign irq_o = |(irq_stat_q & irq_en_q);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Count of high centre samples, worked out apart from maj3 so that a broken vote shows.
  wire [1:0] n_high = 2'(votes_q[1]) + 2'(votes_q[0]) + 2'(rx_s);

  property p_hunt_after_reject;
    @(posedge clk_i) disable iff (srst_i)
      (tick && state_q == UARX_START && last_v && voted) |=> state_q == UARX_HUNT;
  endproperty
  a_hunt_after_reject: assert property (p_hunt_after_reject)
    else $error("Rejected start did not return to hunt.");

  property p_start_on_low;
    @(posedge clk_i) disable iff (srst_i)
      (receiver_enable && new_start) |=> (state_q == UARX_START && samp_q == 5'd2);
  endproperty
  a_start_on_low: assert property (p_start_on_low)
    else $error("Falling edge did not start qualification.");

  property p_disable_flush;
    @(posedge clk_i) disable iff (srst_i)
      !receiver_enable |=> (fifo_empty && state_q == UARX_HUNT);
  endproperty
  a_disable_flush: assert property (p_disable_flush)
    else $error("Disable did not flush receiver.");

  property p_fe_store;
    @(posedge clk_i) disable iff (srst_i)
      frame_done |=> shift_full_q && shift_ent_q[8] == !$past(voted);
  endproperty
  a_fe_store: assert property (p_fe_store)
    else $error("Framing error not stored with frame.");

  property p_no_tick_hold;
    @(posedge clk_i) disable iff (srst_i)
      (!baud_tick_i && receiver_enable) |=> $stable(samp_q) && $stable(state_q);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold)
    else $error("Sampling moved without a baud tick.");

  property p_hunt_needs_high;
    @(posedge clk_i) disable iff (srst_i)
      (state_q == UARX_HUNT && receiver_enable) |=> state_q != UARX_START;
  endproperty
  a_hunt_needs_high: assert property (p_hunt_needs_high)
    else $error("Start accepted without an idle high.");

  property p_samp_range;
    @(posedge clk_i) disable iff (srst_i)
      state_q == UARX_BITS |-> (samp_q >= 5'd1 && samp_q <= spb);
  endproperty
  a_samp_range: assert property (p_samp_range)
    else $error("Bit state count out of range.");

  property p_overrun;
    @(posedge clk_i) disable iff (srst_i)
      (new_start && fifo_full && shift_full_q && receiver_enable) |=> dor_pend_q;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("Overrun not flagged.");

  // A status event must leave its sticky bit set even when a clear lands with it.
  property p_irq_sticky;
    @(posedge clk_i) disable iff (srst_i)
      (|irq_set) |=> ((irq_stat_q & $past(irq_set)) == $past(irq_set));
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("Status event lost against a clear.");

  // A qualified start hands over to data recovery with the bit timing already set.
  sequence s_start_ok;
    start_ok;
  endsequence

  sequence s_bits_aligned;
    state_q == UARX_BITS && bit_q == 4'd0 && samp_q == v_first + 5'd3;
  endsequence

  property p_realign;
    @(posedge clk_i) disable iff (srst_i)
      s_start_ok |=> s_bits_aligned;
  endproperty
  a_realign: assert property (p_realign)
    else $error("Qualified start did not align data recovery.");

  property p_vote_majority;
    @(posedge clk_i) disable iff (srst_i)
      (tick && state_q == UARX_BITS && last_v && !is_stop) |=>
        shift_q[$past(bit_q)] == ($past(n_high) >= 2'd2);
  endproperty
  a_vote_majority: assert property (p_vote_majority)
    else $error("Data bit does not follow the sample majority.");

  property p_stop_hunt;
    @(posedge clk_i) disable iff (srst_i)
      frame_done |=> (state_q == UARX_HUNT && samp_q == 5'd0);
  endproperty
  a_stop_hunt: assert property (p_stop_hunt)
    else $error("Receiver did not hunt right after the stop vote.");
endmodule // uarx_core

// ### testbench/uarx_tx_model.sv
// Behavioural remote serial transmitter driving the receive line.
module uarx_tx_model (
  // Clock
  input  wire logic clk_i,
  // Line
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd_o = 1'b1;
  // Holds one level for a number of clock cycles.
  task automatic hold(input logic v, input int n);
    rxd_o <= v;
    repeat (n) @(posedge clk_i);
  endtask
  // Bit times are exact tick multiples, well inside the rate tolerance.
  task automatic send(input logic [8:0] d, input int nb, input logic sv, input int bc,
                      input int sc, input int sp);
    hold(1'b0, bc);
    for (int i = 0; i < nb; i++) begin
      if (i == sp) begin
        // A one-tick spike mid-bit can corrupt at most one centre sample.
        hold(d[i], bc / 2);
        hold(~d[i], 4);
        hold(d[i], bc / 2 - 4);
      end else begin
        hold(d[i], bc);
      end
    end
    hold(sv, sc);
    if (!sv) begin
      hold(1'b1, bc);
    end
  endtask
endmodule  // uarx_tx_model

// ### testbench/tb.sv
// Self-checking testbench for the serial receive front end.
`include "uarx_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int NB = 64;
  localparam int DB = 32;
  logic       clk_i       = 1'b0;
  logic       srst_i      = 1'b1;
  logic       baud_tick_i = 1'b0;
  logic [1:0] tcnt_q      = 2'h0;
  logic       rxd;
  logic [3:0] addr_i      = 4'h0;
  logic [7:0] wdata_i     = 8'h00;
  logic       wr_i        = 1'b0;
  logic       rd_i        = 1'b0;
  logic [7:0] rdata_o;
  logic       irq_o;
  int         n_errors    = 0;
  int         n_tests     = 0;
  always #12.5 clk_i = ~clk_i;
  // One tick every four cycles, so a normal bit is 64 cycles.
  always @(posedge clk_i) begin
    tcnt_q      <= tcnt_q + 2'h1;
    baud_tick_i <= (tcnt_q == 2'h3);
  end
  uarx_tx_model u_tx (.clk_i(clk_i), .rxd_o(rxd));
  uarx_core u_dut (.clk_i(clk_i), .srst_i(srst_i), .baud_tick_i(baud_tick_i), .rxd_i(rxd),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o));
  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    // One idle edge so that a following call never raises the strobe as it falls.
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, e);
    @(posedge clk_i);
  endtask
  task automatic ckirq(input logic e);
    @(negedge clk_i);
    chk({7'h00, irq_o}, {7'h00, e});
    @(posedge clk_i);
  endtask
  // Status must be read before data, since the data read pops the entry.
  task automatic rx(input logic [7:0] st, input logic [7:0] d);
    rd(`UARX_REG_STATUS, st);
    rd(`UARX_REG_DATA, d);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rd(`UARX_REG_CTRL, `UARX_CTRL_RESET);
    rd(4'hf, 8'h00);
    wr(`UARX_REG_STATUS, 8'hff);
    rd(`UARX_REG_STATUS, 8'h00);
    ckirq(1'b0);
  endtask
  task automatic t_normal;
    wr(`UARX_REG_CTRL, 8'h01);
    wr(`UARX_REG_IRQ_EN, 8'h01);
    u_tx.send(9'h0a5, 8, 1'b1, NB, 2 * NB, 2);
    ckirq(1'b1);
    rx(8'h01, 8'ha5);
    wr(`UARX_REG_IRQ_EN, 8'h00);
    ckirq(1'b0);
    wr(`UARX_REG_IRQ_EN, 8'h01);
    ckirq(1'b1);
    wr(`UARX_REG_IRQ_CLR, 8'h01);
    ckirq(1'b0);
    rd(`UARX_REG_IRQ_STAT, 8'h00);
  endtask
  task automatic t_double;
    wr(`UARX_REG_CTRL, 8'h03);
    u_tx.send(9'h03c, 8, 1'b1, DB, DB, -1);
    u_tx.send(9'h0c3, 8, 1'b1, DB, DB, -1);
    rx(8'h01, 8'h3c);
    rx(8'h01, 8'hc3);
  endtask
  task automatic t_glitch;
    wr(`UARX_REG_CTRL, 8'h01);
    u_tx.hold(1'b0, 24);
    u_tx.hold(1'b1, 2 * NB);
    rd(`UARX_REG_STATUS, 8'h00);
    u_tx.send(9'h05a, 8, 1'b1, NB, NB, -1);
    rx(8'h01, 8'h5a);
    wr(`UARX_REG_CTRL, 8'h03);
    u_tx.hold(1'b0, 8);
    u_tx.hold(1'b1, 2 * DB);
    rd(`UARX_REG_STATUS, 8'h00);
  endtask
  task automatic t_frame;
    wr(`UARX_REG_CTRL, 8'h01);
    wr(`UARX_REG_IRQ_CLR, 8'h0f);
    u_tx.send(9'h081, 8, 1'b0, NB, NB, -1);
    rx(8'h03, 8'h81);
    rd(`UARX_REG_IRQ_STAT, 8'h03);
    wr(`UARX_REG_IRQ_EN, 8'h02);
    ckirq(1'b1);
    wr(`UARX_REG_IRQ_CLR, 8'h0f);
    ckirq(1'b0);
  endtask
  task automatic t_parity;
    for (int m = 0; m < 4; m++) begin
      wr(`UARX_REG_CTRL, m[0] ? 8'h0d : 8'h05);
      u_tx.send({^8'h37 ^ m[0] ^ m[1], 8'h37}, 9, 1'b1, NB, NB, -1);
      rx(m[1] ? 8'h09 : 8'h01, 8'h37);
    end
  endtask
  task automatic t_b2b;
    wr(`UARX_REG_CTRL, 8'h01);
    u_tx.send(9'h011, 8, 1'b1, NB, 48, -1);
    u_tx.send(9'h0ee, 8, 1'b1, NB, 48, -1);
    rx(8'h01, 8'h11);
    rx(8'h01, 8'hee);
  endtask
  task automatic t_overrun;
    wr(`UARX_REG_IRQ_CLR, 8'h0f);
    for (int i = 0; i < 4; i++) begin
      u_tx.send({1'b0, 8'h40 + 8'(i)}, 8, 1'b1, NB, NB, -1);
    end
    rd(`UARX_REG_IRQ_STAT, 8'h05);
    rd(`UARX_REG_DATA, 8'h40);
    rd(`UARX_REG_DATA, 8'h41);
    rx(8'h05, 8'h43);
  endtask
  task automatic t_disable;
    wr(`UARX_REG_CTRL, 8'h01);
    u_tx.send(9'h099, 8, 1'b1, NB, NB, -1);
    fork
      u_tx.send(9'h066, 8, 1'b1, NB, NB, -1);
      begin
        repeat (300) @(posedge clk_i);
        wr(`UARX_REG_CTRL, 8'h00);
      end
    join
    wr(`UARX_REG_CTRL, 8'h01);
    rd(`UARX_REG_STATUS, 8'h00);
    repeat (4 * NB) @(posedge clk_i);
    rd(`UARX_REG_STATUS, 8'h00);
  endtask
  // ---------------------------------------------------------------
  // Sequence and verdict
  // ---------------------------------------------------------------
  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_normal;
    t_double;
    t_glitch;
    t_frame;
    t_parity;
    t_b2b;
    t_overrun;
    t_disable;
    test_done;
  end
  // A hung scenario counts as a failure.
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    test_done;
  end
endmodule  // tb
